// ---- verilog/i2cm_top.sv ----
`default_nettype none
// Notes on behaviour
// R1: master only, never answers as slave
// R2: sole master, no arbitration hardware
// R3: bit rate at most 400 kbps
// R4: 7-bit and 10-bit addressing, read and write
// R5: no limit on bytes per transfer
// R6: three sources: transmit, receive, not-acknowledge
// R7: transmit irq needs enable and empty data
// R8: request data when idle
// R9: request data when start set, nothing loaded
// R10: request data on address byte, write direction
// R11: request data on 10-bit address byte
// R12: request data on write data byte
// R13: data write clears transmit irq
// R14: receive irq on each received byte
// R15: data read clears receive irq
// R16: pending receive irq stalls bus activity
// R17: nack irq when no start/stop pending
// R18: only start or stop request clears nack
// R19: start/stop with scl high, else sda moves low
// R20: msb first, then one acknowledge bit
// R21: first byte is address plus direction bit
// R22: receiver nacks last byte, then stop/restart
// R23: open-drain lines, both lines sampled
module i2cm_top import i2cm_pkg::*; #(
  parameter int QUARTER = I2CM_QUARTER_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic link_clk,
  input wire logic start_req,
  input wire logic stop_req,
  input wire logic data_wr,
  input wire logic [I2CM_DATA_W-1:0] data_in,
  input wire logic data_rd,
  input wire logic transmit_irq_enable,
  input wire logic nack_next,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe,
  output logic [I2CM_DATA_W-1:0] data_out,
  output logic tx_irq,
  output logic rx_irq,
  output logic nack_interrupt,
  output logic start_pending,
  output logic stop_pending,
  output logic read_dir,
  output logic busy
);
  if (QUARTER < 1 || QUARTER > I2CM_QUARTER_MAX) begin : g_bad_quarter
    $error("QUARTER out of range");
  end
  ////////////////////////////////////////////////////////////////////////////
  // system clock side: data register, request bits, flags
  logic data_full;
  logic in_xfer;
  logic req_tgl;
  logic ack_seen;
  logic ack_s;
  i2cm_cmd_t cmd;
  logic [I2CM_DATA_W-1:0] cmd_byte;
  logic cmd_ack;
  logic [I2CM_DATA_W-1:0] shreg;
  logic rx_nack;
  logic ack_tgl;

  i2cm_sync #(.W(1)) u_ack_sync (.clk(clk), .srst(srst), .d(ack_tgl), .q(ack_s));

  wire done = (ack_s != ack_seen);
  wire pend = (req_tgl != ack_seen);
  wire can_issue = ~pend & ~done & ~rx_irq; // see R16
  wire go_start = can_issue & start_pending & data_full; // see R4
  wire go_stop = can_issue & ~go_start & stop_pending & in_xfer;
  wire drop_stop = can_issue & ~go_start & stop_pending & ~in_xfer;
  wire go_xfer = can_issue & ~start_pending & ~stop_pending & in_xfer & ~nack_interrupt;
  wire go_write = go_xfer & ~read_dir & data_full; // see R5
  wire go_read = go_xfer & read_dir; // see R1
  wire issue = go_start | go_stop | go_write | go_read;
  wire done_read = done & (cmd == I2CM_CMD_READ);
  wire done_nack = done & (cmd != I2CM_CMD_STOP) & rx_nack;
  wire nack_set = done_nack & ~start_pending & ~stop_pending; // see R17
  wire tenbit_addr = (cmd == I2CM_CMD_START) & (cmd_byte[7:3] == I2CM_TENBIT_PFX);
  wire idle_want = ~in_xfer & ~pend; // see R8
  wire start_want = start_pending & ~pend & ~data_full; // see R9
  wire addr_want = pend & (cmd == I2CM_CMD_START) & ~read_dir; // see R10
  wire tenbit_want = pend & tenbit_addr; // see R11
  wire write_want = pend & (cmd == I2CM_CMD_WRITE); // see R12
  wire tx_want = idle_want | start_want | addr_want | tenbit_want | write_want;
  wire next_tx_irq = transmit_irq_enable & ~data_full & ~data_wr & tx_want; // see R7 R13
  wire next_busy = in_xfer | pend | issue;
  i2cm_cmd_t next_cmd;
  assign next_cmd = go_start ? I2CM_CMD_START :
                    go_stop ? I2CM_CMD_STOP :
                    go_write ? I2CM_CMD_WRITE : I2CM_CMD_READ;

  always_ff @(posedge clk) begin
    if (srst) begin
      req_tgl <= 1'b0;
      cmd <= I2CM_CMD_STOP;
      cmd_byte <= '0;
      cmd_ack <= 1'b0;
    end else if (issue) begin
      req_tgl <= ~req_tgl;
      cmd <= next_cmd;
      cmd_byte <= data_out;
      cmd_ack <= ~nack_next; // see R22
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ack_seen <= 1'b0;
    end else if (done) begin
      ack_seen <= ack_s;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      data_out <= '0;
    end else if (data_wr) begin
      data_out <= data_in;
    end else if (done_read) begin
      data_out <= shreg; // see R14
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      data_full <= 1'b0;
    end else if (data_wr) begin
      data_full <= 1'b1;
    end else if (go_start | go_write) begin
      data_full <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      in_xfer <= 1'b0;
      read_dir <= 1'b0;
    end else if (go_start) begin
      in_xfer <= 1'b1;
      read_dir <= data_out[0]; // see R21
    end else if (go_stop) begin
      in_xfer <= 1'b0;
      read_dir <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      start_pending <= 1'b0;
    end else if (start_req) begin
      start_pending <= 1'b1;
    end else if (go_start) begin
      start_pending <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      stop_pending <= 1'b0;
    end else if (stop_req) begin
      stop_pending <= 1'b1;
    end else if (go_stop | drop_stop) begin
      stop_pending <= 1'b0;
    end
  end
  // the three interrupt sources; for rx and nack a set in the clearing cycle wins, a data write always clears tx
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_irq <= 1'b0;
    end else if (done_read) begin
      rx_irq <= 1'b1; // see R6 R14
    end else if (data_rd) begin
      rx_irq <= 1'b0; // see R15
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      nack_interrupt <= 1'b0;
    end else if (nack_set) begin
      nack_interrupt <= 1'b1; // see R17
    end else if (start_req | stop_req) begin
      nack_interrupt <= 1'b0; // see R18
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_irq <= 1'b0;
      busy <= 1'b0;
    end else begin
      tx_irq <= next_tx_irq;
      busy <= next_busy;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // link clock side: bit engine driving the two open-drain lines
  logic lrst;
  logic req_s;
  logic [1:0] pins_s;
  i2cm_link_st_t l_state;
  logic [1:0] phase;
  logic [7:0] qcnt;
  logic [3:0] bit_idx;
  logic req_seen;
  logic l_read;
  logic l_ackdrv;

  i2cm_sync #(.W(1)) u_rst_sync (.clk(link_clk), .srst(1'b0), .d(srst), .q(lrst));
  i2cm_sync #(.W(1)) u_req_sync (.clk(link_clk), .srst(lrst), .d(req_tgl), .q(req_s));
  i2cm_sync #(.W(2)) u_pin_sync (.clk(link_clk), .srst(lrst), .d({scl_in, sda_in}), .q(pins_s));

  wire scl_s = pins_s[1]; // see R23
  wire sda_s = pins_s[0]; // see R23
  wire l_idle = (l_state == I2CM_L_IDLE);
  wire st_start = (l_state == I2CM_L_START);
  wire st_bits = (l_state == I2CM_L_BITS);
  wire st_stop = (l_state == I2CM_L_STOP);
  wire capture = l_idle & (req_s != req_seen);
  wire tick = ~l_idle & (qcnt == 8'(QUARTER - 1)); // see R3
  wire stall = (phase == I2CM_PH_HIGH) & ~scl_s;
  wire step = tick & ~stall;
  wire ph_low = step & (phase == I2CM_PH_LOW);
  wire ph_rise = step & (phase == I2CM_PH_RISE);
  wire ph_high = step & (phase == I2CM_PH_HIGH);
  wire ph_fall = step & (phase == I2CM_PH_FALL);
  wire ack_bit = (bit_idx == I2CM_ACK_IDX);
  wire bit_drive = ack_bit ? (l_read & l_ackdrv) : (~l_read & ~shreg[7]); // see R20 R22
  wire finish = ph_fall & (st_stop | (st_bits & ack_bit));
  wire sda_set = (ph_high & st_start) | (ph_low & st_stop) | (ph_low & st_bits & bit_drive);
  wire sda_clr = (ph_low & st_start) | (ph_high & st_stop) | (ph_low & st_bits & ~bit_drive);
  i2cm_link_st_t cap_state;
  assign cap_state = (cmd == I2CM_CMD_START) ? I2CM_L_START :
                     (cmd == I2CM_CMD_STOP) ? I2CM_L_STOP : I2CM_L_BITS;

  always_ff @(posedge link_clk) begin
    if (lrst) begin
      l_state <= I2CM_L_IDLE;
    end else if (capture) begin
      l_state <= cap_state;
    end else if (ph_fall & st_start) begin
      l_state <= I2CM_L_BITS;
    end else if (finish) begin
      l_state <= I2CM_L_IDLE;
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst | capture) begin
      qcnt <= I2CM_Q_ZERO;
      phase <= I2CM_PH_LOW;
    end else if (step) begin
      qcnt <= I2CM_Q_ZERO;
      phase <= phase + I2CM_PH_ONE;
    end else if (~tick & ~l_idle) begin
      qcnt <= qcnt + I2CM_Q_ONE;
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst | capture) begin
      bit_idx <= I2CM_IDX_ZERO;
    end else if (ph_fall & st_bits & ~ack_bit) begin
      bit_idx <= bit_idx + I2CM_IDX_ONE;
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst) begin
      req_seen <= 1'b0;
      l_read <= 1'b0;
      l_ackdrv <= 1'b0;
    end else if (capture) begin
      req_seen <= req_s;
      l_read <= (cmd == I2CM_CMD_READ);
      l_ackdrv <= cmd_ack;
    end
  end
  // shift msb first; each sampled bit enters at the bottom
  always_ff @(posedge link_clk) begin
    if (lrst) begin
      shreg <= '0;
    end else if (capture) begin
      shreg <= cmd_byte;
    end else if (ph_high & st_bits & ~ack_bit) begin
      shreg <= {shreg[6:0], sda_s}; // see R20
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst) begin
      rx_nack <= 1'b0;
    end else if (ph_high & st_bits & ack_bit) begin
      rx_nack <= sda_s;
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst) begin
      ack_tgl <= 1'b0;
    end else if (finish) begin
      ack_tgl <= ~ack_tgl;
    end
  end
  // sda moves only with scl low except for start and stop
  always_ff @(posedge link_clk) begin
    if (lrst) begin
      sda_oe <= 1'b0;
    end else if (sda_set) begin
      sda_oe <= 1'b1; // see R19
    end else if (sda_clr) begin
      sda_oe <= 1'b0; // see R19
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst) begin
      scl_oe <= 1'b0;
    end else if (ph_rise) begin
      scl_oe <= 1'b0;
    end else if (ph_fall & ~st_stop) begin
      scl_oe <= 1'b1; // see R2
    end
  end
  // open drain: the driven level is always low
  always_ff @(posedge link_clk) begin
    scl_out <= 1'b0; // see R23
    sda_out <= 1'b0;
  end
endmodule : i2cm_top
`default_nettype wire

// ---- verilog/i2cm_pkg.sv ----
`default_nettype none
package i2cm_pkg;
  localparam int I2CM_MAX_KBPS = 400;
  localparam int I2CM_BIT_NS = 1000000 / I2CM_MAX_KBPS;
  localparam int I2CM_LINK_NS = 80;
  // quarter of the shortest bit, rounded up to whole link cycles
  localparam int I2CM_QUARTER_CYC = (I2CM_BIT_NS + 4 * I2CM_LINK_NS - 1) / (4 * I2CM_LINK_NS);
  localparam int I2CM_QUARTER_MAX = 255;
  localparam int I2CM_DATA_W = 8;
  localparam logic [3:0] I2CM_ACK_IDX = 4'h8;
  localparam logic [3:0] I2CM_IDX_ZERO = 4'h0;
  localparam logic [3:0] I2CM_IDX_ONE = 4'h1;
  localparam logic [1:0] I2CM_PH_LOW = 2'h0;
  localparam logic [1:0] I2CM_PH_RISE = 2'h1;
  localparam logic [1:0] I2CM_PH_HIGH = 2'h2;
  localparam logic [1:0] I2CM_PH_FALL = 2'h3;
  localparam logic [1:0] I2CM_PH_ONE = 2'h1;
  localparam logic [4:0] I2CM_TENBIT_PFX = 5'h1E;
  localparam logic [7:0] I2CM_Q_ONE = 8'h01;
  localparam logic [7:0] I2CM_Q_ZERO = 8'h00;

  typedef enum logic [1:0] {
    I2CM_CMD_START,
    I2CM_CMD_WRITE,
    I2CM_CMD_READ,
    I2CM_CMD_STOP
  } i2cm_cmd_t;

  typedef enum logic [1:0] {
    I2CM_L_IDLE,
    I2CM_L_START,
    I2CM_L_BITS,
    I2CM_L_STOP
  } i2cm_link_st_t;
endpackage : i2cm_pkg
`default_nettype wire

// ---- verilog/i2cm_sync.sv ----
`default_nettype none
// three-stage synchroniser; output follows once stages two and three agree
module i2cm_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  wire agree = (s2 == s3);

  always_ff @(posedge clk) begin
    if (srst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else if (agree) begin
      q <= s3;
    end
  end
endmodule : i2cm_sync
`default_nettype wire

// ---- bench/i2cm_asserts.sv ----
`default_nettype none
module i2cm_asserts #(
  parameter int QUARTER = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic link_clk,
  input wire logic start_req,
  input wire logic stop_req,
  input wire logic data_wr,
  input wire logic data_rd,
  input wire logic transmit_irq_enable,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic scl_out,
  input wire logic sda_out,
  input wire logic tx_irq,
  input wire logic rx_irq,
  input wire logic nack_interrupt,
  input wire logic read_dir
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SPAN = 8 * QUARTER;
  ////////////////////////////////////////////////////////////
  tx_gate_a: assert property (@(posedge clk) disable iff (srst)
    tx_irq |-> $past(transmit_irq_enable)) else $error("tx irq without enable");
  tx_clear_a: assert property (@(posedge clk) disable iff (srst)
    data_wr |-> ##[1:2] !tx_irq) else $error("tx irq kept");
  rx_clear_a: assert property (@(posedge clk) disable iff (srst)
    data_rd && rx_irq |-> ##[1:2] !rx_irq) else $error("rx irq kept");
  rx_dir_a: assert property (@(posedge clk) disable iff (srst)
    $rose(rx_irq) |-> read_dir) else $error("rx irq on write");
  rx_stall_a: assert property (@(posedge clk) disable iff (srst)
    rx_irq && $past(rx_irq) |-> $stable(scl_oe) && $stable(sda_oe))
    else $error("bus moved during rx irq");
  nack_keep_a: assert property (@(posedge clk) disable iff (srst)
    $fell(nack_interrupt) |-> $past(start_req) || $past(stop_req)
      || $past(start_req, 2) || $past(stop_req, 2)) else $error("nack lost");
  nack_clear_a: assert property (@(posedge clk) disable iff (srst)
    (start_req || stop_req) && nack_interrupt |-> ##[1:2] !nack_interrupt)
    else $error("nack kept");
  start_a: assert property (@(posedge link_clk) disable iff (srst)
    $rose(sda_oe) && !scl_oe |-> ##[1:SPAN] scl_oe) else $error("bad start");
  stop_a: assert property (@(posedge link_clk) disable iff (srst)
    $fell(sda_oe) && !scl_oe && !$past(scl_oe) |=> !scl_oe [*4]) else $error("bad stop");
  od_low_a: assert property (@(posedge link_clk) disable iff (srst)
    !scl_out && !sda_out) else $error("line driven high");
endmodule : i2cm_asserts
`default_nettype wire

// ---- bench/i2cm_slave.sv ----
`default_nettype none
module i2cm_slave (
  input wire logic scl,
  input wire logic sda,
  input wire logic nack,
  input wire logic [7:0] tx_byte,
  output var logic sda_oe,
  output var logic got,
  output var logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh = 8'h00;
  logic [7:0] cur;
  logic rd = 1'b0;
  int n = 0;
  int k = 0;
  initial begin
    sda_oe = 1'b0;
    got = 1'b0;
    rx_byte = 8'h00;
  end
  ////////////////////////////////////////////////////////////
  // start or stop restarts the frame
  always @(sda) begin
    if (scl === 1'b1) begin
      n = 0;
      k = 0;
      rd = 1'b0;
    end
  end
  always @(posedge scl) begin
    if (n < 8 && !(rd && k > 0)) sh = {sh[6:0], sda};
    if (n == 7 && !(rd && k > 0)) begin
      rx_byte = sh;
      got = !got;
      if (k == 0) rd = sh[0];
    end
    if (n == 8 && rd && k > 0 && sda) rd = 1'b0;
    n = (n == 8) ? 0 : n + 1;
    if (n == 0) k++;
  end
  always @(negedge scl) begin
    cur = tx_byte + 8'(k - 1);
    if (n == 8) sda_oe = !(rd && k > 0) && !nack;
    else sda_oe = rd && k > 0 && !cur[7 - n];
  end
endmodule : i2cm_slave
`default_nettype wire

// ---- bench/i2cm_top_tb.sv ----
`default_nettype none
module i2cm_top_tb import i2cm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int QUARTER = 2;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic srst = 1'b1;
  logic start_req, stop_req, data_wr, data_rd, transmit_irq_enable, nack_next, s_nack;
  logic [I2CM_DATA_W-1:0] data_in, data_out, s_tx, s_rx;
  logic scl_out, scl_oe, sda_out, sda_oe, tx_irq, rx_irq, nack_interrupt;
  logic start_pending, stop_pending, read_dir, busy, s_oe, s_got, rx_d;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'h00013F64;
  int fails = 0;
  int checked = 0;
  wire scl_w = !(scl_oe && !scl_out);
  wire sda_w = !((sda_oe && !sda_out) || s_oe);
  initial forever #10 clk = !clk;
  initial begin
    #7;
    forever #40 link_clk = !link_clk;
  end
  i2cm_top #(.QUARTER(QUARTER)) u_dut (
    .clk, .srst, .link_clk, .start_req, .stop_req, .data_wr, .data_in, .data_rd,
    .transmit_irq_enable, .nack_next, .scl_in(scl_w), .sda_in(sda_w), .scl_out,
    .scl_oe, .sda_out, .sda_oe, .data_out, .tx_irq, .rx_irq, .nack_interrupt,
    .start_pending, .stop_pending, .read_dir, .busy
  );
  i2cm_slave u_slave (
    .scl(scl_w), .sda(sda_w), .nack(s_nack), .tx_byte(s_tx), .sda_oe(s_oe),
    .got(s_got), .rx_byte(s_rx)
  );
  ////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    checked++;
    if (a !== e) begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, a, e);
    end
  endtask : chk
  task automatic end_sim();
    if (fails == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task automatic go(input logic [3:0] p, input logic [7:0] d);
    if (p[3]) start_req = 1'b1;
    if (p[2]) stop_req = 1'b1;
    if (p[1]) data_wr = 1'b1;
    if (p[0]) data_rd = 1'b1;
    data_in = d;
    @(posedge clk);
    #1;
    if (p[3]) start_req = 1'b0;
    if (p[2]) stop_req = 1'b0;
    if (p[1]) data_wr = 1'b0;
    if (p[0]) data_rd = 1'b0;
  endtask : go
  task automatic wt(input int s);
    int i;
    for (i = 0; i < 3000; i++) begin
      @(posedge clk);
      #1;
      if (i < 2) continue;
      if (s == 0 && tx_irq === 1'b1) break;
      if (s == 1 && rx_irq === 1'b1) break;
      if (s == 2 && busy === 1'b0 && stop_pending === 1'b0) break;
      if (s == 3 && nack_interrupt === 1'b1) break;
    end
    chk(8'(i == 3000), 8'h00);
  endtask : wt
  task automatic wr_xfer(input logic [7:0] a, input int n, input logic sf);
    logic [7:0] d;
    exp_q.push_back(a);
    go(4'h2, a);
    if (!sf) go(4'h8, a);
    for (int i = 0; i < n; i++) begin
      wt(0);
      chk({7'h00, read_dir}, 8'h00);
      d = rnd();
      exp_q.push_back(d);
      go(4'h2, d);
    end
    wt(0);
    go(4'h4, 8'h00);
    wt(2);
  endtask : wr_xfer
  task automatic rd_xfer(input logic [7:0] a, input int n);
    s_tx = rnd();
    exp_q.push_back(a);
    nack_next = (n == 1);
    go(4'h2, a);
    go(4'h8, a);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(s_tx + 8'(i));
      wt(1);
      chk({6'h00, read_dir, tx_irq}, 8'h02);
      nack_next = (i == n - 2);
      go(4'h1, 8'h00);
    end
    wt(3);
    go(4'h4, 8'h00);
    wt(2);
    chk({7'h00, nack_interrupt}, 8'h00);
  endtask : rd_xfer
  ////////////////////////////////////////////////////////////
  always @(s_got) begin
    if (!srst) chk(s_rx, exp_q.pop_front());
  end
  always @(posedge clk) begin
    rx_d <= rx_irq;
    if (rx_irq === 1'b1 && rx_d !== 1'b1) chk(data_out, exp_q.pop_front());
  end
  initial begin
    #400000;
    fails++;
    end_sim();
  end
  initial begin
    {start_req, stop_req, data_wr, data_rd} = 4'h0;
    {transmit_irq_enable, nack_next, s_nack, s_tx} = 11'h000;
    data_in = 8'h00;
    repeat (40) @(posedge clk);
    #1;
    srst = 1'b0;
    wt(2);
    chk({7'h00, tx_irq}, 8'h00);
    transmit_irq_enable = 1'b1;
    wt(0);
    wr_xfer(8'hA0, 3, 1'b0);
    go(4'h8, 8'h00);
    wt(0);
    chk({7'h00, start_pending}, 8'h01);
    wr_xfer(8'hF4, 2, 1'b1);
    rd_xfer(8'hA1, 1);
    rd_xfer(8'hA3, 3);
    s_nack = 1'b1;
    exp_q.push_back(8'hA4);
    go(4'h2, 8'hA4);
    go(4'h8, 8'h00);
    wt(3);
    go(4'h1, 8'h00);
    go(4'h0, 8'h00);
    chk({7'h00, nack_interrupt}, 8'h01);
    s_nack = 1'b0;
    go(4'h4, 8'h00);
    wt(2);
    chk({7'h00, nack_interrupt}, 8'h00);
    chk(8'(exp_q.size()), 8'h00);
    end_sim();
  end
endmodule : i2cm_top_tb
bind i2cm_top i2cm_asserts #(.QUARTER(QUARTER)) u_chk (
  .clk, .srst, .link_clk, .start_req, .stop_req, .data_wr, .data_rd,
  .transmit_irq_enable, .scl_oe, .sda_oe, .scl_out, .sda_out, .tx_irq, .rx_irq,
  .nack_interrupt, .read_dir
);
`default_nettype wire
